// [rtl/sac_adc_ctrl.sv]
// Successive approximation converter control with temperature sensor channel
//
// Contract
// - Ten-bit successive approximation result kept in the high/low result pair.
// - Five-bit channel code picks pins 0-16, sensor, DAC or reference buffer.
// - Converter off disconnects every multiplexer input from the sample-and-hold.
// - Three-bit clock select: divide by 2,4,8,16,32,64 or RC oscillator.
// - One conversion lasts eleven and a half bit periods.
// - Justify bit 0 places result left, 1 places it right.
// - Positive reference field chooses external pin or supply rail.
// - Negative reference bit chooses external pin or ground.
// - Completion raises an interrupt request that can wake the device.
// - Divided clocks follow system clock changes; RC clock does not.
// - Temperature sensor powered only while its enable bit is set.
// - Sensor range bit set gives high range, clear gives low range.
// - Writing go while on starts; go with turn-on write is ignored.
// - Completion clears go, sets done flag, updates both result registers.
// - Clearing go early loads partial result, missing bits copy last bit.
`timescale 1ns/1ps
`include "sac_defines.svh"
module sac_adc_ctrl #(
   parameter int RES_W = 10
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic compIn,
   input wire logic rcOscIn,
   input wire logic fvrReadyIn,
   input wire logic sleepIn,
   output logic [4:0] channelSelect,
   output logic muxConnect,
   output logic sampleHold,
   output logic [RES_W-1:0] dacCode,
   output logic [1:0] posRefSel,
   output logic negRefSel,
   output logic tempSensorPower,
   output logic tempSensorRange,
   output logic fixedRefEnable,
   output logic [1:0] converterRefGain,
   output logic [1:0] peripheralRefGain,
   output logic convIrq,
   output logic wakeReq
);
   localparam int IDXW = $clog2(RES_W);
   localparam int LAST_DEC = `SAC_SETUP_HALVES + 2 * (RES_W - 1);
   localparam int HALVES = LAST_DEC + 2;

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   // The result pair is sixteen bits wide and the half counter is six bits
   initial begin
      if (RES_W < 2 || RES_W > 16) begin
         $error("RES_W must lie between 2 and 16");
      end
   end

   logic ack_reg;
   logic [31:0] rdData_reg;
   logic onReg_reg;
   logic goReg_reg;
   logic [4:0] chan_reg;
   logic just_reg;
   logic [2:0] clkSel_reg;
   logic nref_reg;
   logic [1:0] pref_reg;
   logic fvEn_reg;
   logic temp_sensor_enable_reg;
   logic temp_sensor_range_reg;
   logic [1:0] cdaGain_reg;
   logic [1:0] adcGain_reg;
   logic done_reg;
   logic [RES_W-1:0] result_reg;
   logic [RES_W-1:0] sar_reg;
   logic [IDXW-1:0] bitIdx_reg;
   logic lastBit_reg;
   logic [5:0] halfCnt_reg;
   logic [1:0] compSync_reg;
   logic [1:0] rdySync_reg;
   sac_pkg::sac_state_type state_reg;
   logic wrAcc;
   logic rdAcc;
   logic wrC0;
   logic goWriteSet;
   logic goWriteClr;
   logic tick;
   logic decide;
   logic doneEv;
   logic abortEv;
   logic sleepKill;
   logic [15:0] resPair;

   sac_tad_if tadIf ();

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // Place the result in the sixteen-bit pair, unused bits zero
   function automatic logic [15:0] fmtResult(input logic [RES_W-1:0] r, input logic right);
      fmtResult = right ? 16'(r) : (16'(r) << (16 - RES_W));
   endfunction

   // Bits from the trial position down take the value of the last decided bit
   function automatic logic [RES_W-1:0] fillPartial(input logic [RES_W-1:0] d, input logic [IDXW-1:0] idx,
                                                    input logic b);
      logic [RES_W-1:0] f;
      f = d;
      for (int i = 0; i < RES_W; i++) begin
         if (i <= int'(idx)) begin
            f[i] = b;
         end
      end
      fillPartial = f;
   endfunction

   // Codes that really connect a source; the gap between pins and sensor connects nothing
   function automatic logic chanOk(input logic [4:0] c);
      chanOk = (c <= `SAC_CHAN_LAST_PIN) || (c >= `SAC_CHAN_TEMP);
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Comparator and reference-ready come from the analog side
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         compSync_reg <= 2'h0;
         rdySync_reg <= 2'h0;
      end else begin
         compSync_reg <= {compSync_reg[0], compIn};
         rdySync_reg <= {rdySync_reg[0], fvrReadyIn};
      end
   end

   // ----------------------------------------
   // Avalon-MM slave
   // ----------------------------------------
   // Every access waits exactly one cycle; simpler than a zero-wait decode path
   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
   assign wrAcc = avs_write && ack_reg && avs_byteenable[0];
   assign rdAcc = avs_read && !ack_reg;
   assign wrC0 = wrAcc && (avs_address == `SAC_IDX_CTRL0);
   assign avs_readdata = rdData_reg;
   assign resPair = fmtResult(result_reg, just_reg);

   // Acknowledge toggles so back-to-back requests each see one wait cycle
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (avs_read || avs_write) && !ack_reg;
      end
   end

   // Read data captured during the wait cycle, stands at the answering edge
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rdData_reg <= 32'h0000_0000;
      end else if (rdAcc) begin
         if (avs_address == `SAC_IDX_CTRL0) begin
            rdData_reg <= {25'h000_0000, chan_reg, goReg_reg, onReg_reg};
         end else if (avs_address == `SAC_IDX_CTRL1) begin
            rdData_reg <= {24'h00_0000, just_reg, clkSel_reg, 1'b0, nref_reg, pref_reg};
         end else if (avs_address == `SAC_IDX_RESH) begin
            rdData_reg <= {24'h00_0000, resPair[15:8]};
         end else if (avs_address == `SAC_IDX_RESL) begin
            rdData_reg <= {24'h00_0000, resPair[7:0]};
         end else if (avs_address == `SAC_IDX_REFTS) begin
            rdData_reg <= {24'h00_0000, fvEn_reg, rdySync_reg[1], temp_sensor_enable_reg, temp_sensor_range_reg, cdaGain_reg, adcGain_reg};
         end else if (avs_address == `SAC_IDX_STAT) begin
            rdData_reg <= {31'h0000_0000, done_reg};
         end else begin
            rdData_reg <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   // Converter on, channel, clock, references and justification
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         onReg_reg <= 1'b0;
         chan_reg <= `SAC_RST_CHAN;
         just_reg <= 1'b0;
         clkSel_reg <= `SAC_RST_CS;
         nref_reg <= 1'b0;
         pref_reg <= `SAC_RST_PREF;
      end else if (wrC0) begin
         onReg_reg <= avs_writedata[`SAC_C0_ON];
         chan_reg <= avs_writedata[`SAC_C0_CHAN_HI:`SAC_C0_CHAN_LO];
      end else if (wrAcc && avs_address == `SAC_IDX_CTRL1) begin
         just_reg <= avs_writedata[`SAC_C1_JUST];
         clkSel_reg <= avs_writedata[`SAC_C1_CS_HI:`SAC_C1_CS_LO];
         nref_reg <= avs_writedata[`SAC_C1_NREF];
         pref_reg <= avs_writedata[`SAC_C1_PREF_HI:`SAC_C1_PREF_LO];
      end
   end

   // Reference and temperature sensor control; the ready bit is read-only
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         fvEn_reg <= 1'b0;
         temp_sensor_enable_reg <= 1'b0;
         temp_sensor_range_reg <= 1'b0;
         cdaGain_reg <= `SAC_RST_GAIN;
         adcGain_reg <= `SAC_RST_GAIN;
      end else if (wrAcc && avs_address == `SAC_IDX_REFTS) begin
         fvEn_reg <= avs_writedata[`SAC_RT_FVEN];
         temp_sensor_enable_reg <= avs_writedata[`SAC_RT_TEMP_SENSOR_ENABLE];
         temp_sensor_range_reg <= avs_writedata[`SAC_RT_TEMP_SENSOR_RANGE];
         cdaGain_reg <= avs_writedata[`SAC_RT_CDAG_HI:`SAC_RT_CDAG_LO];
         adcGain_reg <= avs_writedata[`SAC_RT_ADCG_HI:`SAC_RT_ADCG_LO];
      end
   end

   // ----------------------------------------
   // Go flag
   // ----------------------------------------
   // A go in the same write that turns the converter on is dropped
   assign goWriteSet = wrC0 && avs_writedata[`SAC_C0_GO] && avs_writedata[`SAC_C0_ON] && onReg_reg;
   assign goWriteClr = wrC0 && (!avs_writedata[`SAC_C0_GO] || !avs_writedata[`SAC_C0_ON]);

   // Hardware clears go on completion; a software clear mid-way aborts
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         goReg_reg <= 1'b0;
      end else if (goWriteSet) begin
         goReg_reg <= 1'b1;
      end else if (goWriteClr || doneEv || sleepKill) begin
         goReg_reg <= 1'b0;
      end
   end

   AST_GO_NEEDS_ON: assert property ($rose(goReg_reg) |-> $past(onReg_reg) && onReg_reg)
      else $error("Go flag rose while the converter was off");

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   assign tadIf.clkSel = clkSel_reg;
   assign tadIf.run = (state_reg == sac_pkg::SAC_CONV);
   assign tick = tadIf.halfTick;
   // Decisions on odd half periods after the setup, final half ends it
   assign decide = tick && halfCnt_reg >= 6'(`SAC_SETUP_HALVES) && halfCnt_reg <= 6'(LAST_DEC)
                   && halfCnt_reg[0];
   assign doneEv = tadIf.run && tick && halfCnt_reg == 6'(HALVES - 1) && goReg_reg && !goWriteClr;
   assign abortEv = tadIf.run && goWriteClr && onReg_reg && !doneEv;
   // Without the RC clock, sleep stops the conversion and leaves no result
   assign sleepKill = tadIf.run && sleepIn && clkSel_reg[1:0] != `SAC_RC_SEL;

   sac_tad_gen tadGen (
      .clock(clock),
      .rst_b(rst_b),
      .rcOscIn(rcOscIn),
      .tadIf(tadIf)
   );

   // State, half-period count and approximation register
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_reg <= sac_pkg::SAC_IDLE;
         halfCnt_reg <= 6'h00;
         sar_reg <= '0;
         bitIdx_reg <= '0;
         lastBit_reg <= 1'b0;
      end else begin
         case (state_reg)
            sac_pkg::SAC_IDLE: begin
               if (goReg_reg && onReg_reg && !goWriteClr) begin
                  state_reg <= sac_pkg::SAC_CONV;
                  halfCnt_reg <= 6'h00;
                  sar_reg <= RES_W'(1) << (RES_W - 1);
                  bitIdx_reg <= IDXW'(RES_W - 1);
                  lastBit_reg <= 1'b0;
               end
            end
            sac_pkg::SAC_CONV: begin
               if (doneEv || abortEv || sleepKill) begin
                  state_reg <= sac_pkg::SAC_IDLE;
               end else if (tick) begin
                  halfCnt_reg <= halfCnt_reg + 6'h01;
                  if (decide) begin
                     sar_reg[bitIdx_reg] <= compSync_reg[1];
                     lastBit_reg <= compSync_reg[1];
                     if (bitIdx_reg != '0) begin
                        sar_reg[bitIdx_reg - IDXW'(1)] <= 1'b1;
                        bitIdx_reg <= bitIdx_reg - IDXW'(1);
                     end
                  end
               end
            end
            default: state_reg <= sac_pkg::SAC_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Result and done flag
   // ----------------------------------------
   // Both halves of the pair come from one register, so they always match
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         result_reg <= '0;
      end else if (doneEv) begin
         result_reg <= sar_reg;
      end else if (abortEv) begin
         result_reg <= fillPartial(sar_reg, bitIdx_reg, lastBit_reg);
      end
   end

   // Sticky done flag, write one to clear; a completion in the clear cycle wins
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         done_reg <= 1'b0;
      end else if (doneEv) begin
         done_reg <= 1'b1;
      end else if (wrAcc && avs_address == `SAC_IDX_STAT && avs_writedata[`SAC_ST_DONE]) begin
         done_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Analog side controls
   // ----------------------------------------
   assign channelSelect = chan_reg;
   assign muxConnect = onReg_reg && chanOk(chan_reg);
   assign sampleHold = tadIf.run; // Holding while the approximation runs
   assign dacCode = sar_reg;
   assign posRefSel = pref_reg;
   assign negRefSel = nref_reg;
   assign tempSensorPower = temp_sensor_enable_reg;
   assign tempSensorRange = temp_sensor_range_reg;
   assign fixedRefEnable = fvEn_reg;
   assign converterRefGain = adcGain_reg;
   assign peripheralRefGain = cdaGain_reg;
   // Request stands until cleared; it also wakes a sleeping device
   assign convIrq = done_reg;
   assign wakeReq = done_reg && sleepIn;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [5:0] chkTicks_reg;

   // Independent count of half periods seen during one conversion
   always_ff @(posedge clock) begin
      if (!rst_b || !tadIf.run) begin
         chkTicks_reg <= 6'h00;
      end else if (tick) begin
         chkTicks_reg <= chkTicks_reg + 6'h01;
      end
   end

   sequence seqFinish;
      !goReg_reg && done_reg && !tadIf.run;
   endsequence

   sequence seqDivFour;
      !tick ##1 tick;
   endsequence

   AST_CONV_LENGTH: assert property (doneEv |-> chkTicks_reg == 6'd22)
      else $error("Conversion did not last eleven and a half bit periods");

   AST_DONE_EFFECTS: assert property (doneEv |=> seqFinish)
      else $error("Completion did not clear go and set the done flag");

   AST_RESULT_LOADED: assert property (doneEv |=> result_reg == $past(sar_reg))
      else $error("Result pair not updated with the converted value");

   // A conversion that ends right after a tick stops the bit clock, so ending cycles are left out
   AST_DIV_FOUR: assert property (tick && clkSel_reg == 3'b100 && $stable(clkSel_reg)
                                  && !doneEv && !abortEv && !sleepKill ##0 tadIf.run |=> seqDivFour)
      else $error("Divide-by-four bit clock has wrong half period");

   AST_PARTIAL_FILL: assert property (abortEv && bitIdx_reg != IDXW'(RES_W - 1)
                                      |=> result_reg[0] == $past(lastBit_reg))
      else $error("Aborted result low bit does not copy the last converted bit");

   AST_MUX_OFF: assert property (wrC0 && !avs_writedata[`SAC_C0_ON] |=> !muxConnect && !tadIf.run)
      else $error("Multiplexer stayed connected after the converter was turned off");

   AST_JUST_ZERO: assert property (just_reg |-> resPair[15:RES_W] == '0)
      else $error("Right-justified pair has nonzero upper bits");

   AST_IRQ_HOLDS: assert property (doneEv |=> convIrq [*2])
      else $error("Interrupt request did not stand after completion");
endmodule // sac_adc_ctrl

// [rtl/sac_defines.svh]
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH
// ----------------------------------------
// Register word indexes (byte address = 4 x index)
// ----------------------------------------
`define SAC_IDX_CTRL0 3'h0
`define SAC_IDX_CTRL1 3'h1
`define SAC_IDX_RESH 3'h2
`define SAC_IDX_RESL 3'h3
`define SAC_IDX_REFTS 3'h4
`define SAC_IDX_STAT 3'h5
// ----------------------------------------
// converter_control_0 fields
// ----------------------------------------
`define SAC_C0_ON 0
`define SAC_C0_GO 1
`define SAC_C0_CHAN_LO 2
`define SAC_C0_CHAN_HI 6
// ----------------------------------------
// converter_control_1 fields
// ----------------------------------------
`define SAC_C1_PREF_LO 0
`define SAC_C1_PREF_HI 1
`define SAC_C1_NREF 2
`define SAC_C1_CS_LO 4
`define SAC_C1_CS_HI 6
`define SAC_C1_JUST 7
// ----------------------------------------
// reference_and_temp_sensor_control fields
// ----------------------------------------
`define SAC_RT_ADCG_LO 0
`define SAC_RT_ADCG_HI 1
`define SAC_RT_CDAG_LO 2
`define SAC_RT_CDAG_HI 3
`define SAC_RT_TEMP_SENSOR_RANGE 4
`define SAC_RT_TEMP_SENSOR_ENABLE 5
`define SAC_RT_RDY 6
`define SAC_RT_FVEN 7
// ----------------------------------------
// Status fields and reset values
// ----------------------------------------
`define SAC_ST_DONE 0
`define SAC_RST_CHAN 5'h00
`define SAC_RST_CS 3'h0
`define SAC_RST_PREF 2'h0
`define SAC_RST_GAIN 2'h0
// ----------------------------------------
// Conversion timing in half bit periods, RC clock select code and channel code limits
// ----------------------------------------
`define SAC_SETUP_HALVES 3
`define SAC_RC_SEL 2'h3
`define SAC_CHAN_LAST_PIN 5'h10
`define SAC_CHAN_TEMP 5'h1D
`endif

// [rtl/sac_pkg.sv]
// Types shared by the converter control files
package sac_pkg;
   typedef enum logic [0:0] {
      SAC_IDLE,
      SAC_CONV
   } sac_state_type;
endpackage

// [rtl/sac_tad_gen.sv]
// Bit clock generator: system clock divisions or the dedicated RC oscillator
`timescale 1ns/1ps
`include "sac_defines.svh"
module sac_tad_gen (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic rcOscIn,
   sac_tad_if.gen tadIf
);
   logic [4:0] divCnt_reg;
   logic [2:0] rcSync_reg;
   logic rcSel;
   logic divHit;

   // Last divider count of the half bit period for each division setting, one less than its length in system cycles
   function automatic logic [4:0] halfLast(input logic [2:0] sel);
      case (sel)
         3'b000: halfLast = 5'h00;
         3'b100: halfLast = 5'h01;
         3'b001: halfLast = 5'h03;
         3'b101: halfLast = 5'h07;
         3'b010: halfLast = 5'h0F;
         default: halfLast = 5'h1F;
      endcase
   endfunction

   // ----------------------------------------
   // Dedicated RC oscillator capture
   // ----------------------------------------
   // Two stages before any logic looks at the oscillator, third stage for edges
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rcSync_reg <= 3'h0;
      end else begin
         rcSync_reg <= {rcSync_reg[1:0], rcOscIn};
      end
   end

   // ----------------------------------------
   // System clock divider
   // ----------------------------------------
   assign rcSel = (tadIf.clkSel[1:0] == `SAC_RC_SEL);
   assign divHit = (divCnt_reg == halfLast(tadIf.clkSel));

   // Counts system cycles, so the bit period follows any change of system clock
   always_ff @(posedge clock) begin
      if (!rst_b || !tadIf.run || divHit) begin
         divCnt_reg <= 5'h00;
      end else begin
         divCnt_reg <= divCnt_reg + 5'h01;
      end
   end

   // Each RC edge is one half period; the RC rate is independent of the system clock
   assign tadIf.halfTick = tadIf.run && (rcSel ? (rcSync_reg[2] != rcSync_reg[1]) : divHit);
endmodule // sac_tad_gen

// [rtl/sac_tad_if.sv]
// Bit clock link between the converter control and its bit clock generator
`timescale 1ns/1ps
interface sac_tad_if;
   logic [2:0] clkSel;
   logic run;
   logic halfTick;
   modport gen (input clkSel, input run, output halfTick);
   modport user (output clkSel, output run, input halfTick);
endinterface

// [sim/sac_analog_model.sv]
// Far-side model: comparator on a held analog level and the free RC oscillator
`timescale 1ns/1ps
module sac_analog_model #(
   parameter int RES_W = 10
) (
   input wire logic [RES_W-1:0] dacCode,
   input wire logic [RES_W-1:0] level,
   output logic compIn,
   output logic rcOscIn
);
   // ----------------------------------------
   // Comparator and oscillator
   // ----------------------------------------
   // Input at or above the trial code keeps the trial bit
   // Pin held as a pure analog input: no digital buffer is modelled
   assign compIn = (level >= dacCode);
   // Runs free and unrelated in phase to the system clock
   initial begin
      rcOscIn = 1'b0;
      forever #97 rcOscIn = ~rcOscIn;
   end
endmodule // sac_analog_model

// [sim/tb_top.sv]
// Self-checking bench for the converter control
`timescale 1ns/1ps
module tb_top;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [2:0] avs_address = 3'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic compIn;
   logic rcOscIn;
   logic muxConnect;
   logic [9:0] dacCode;
   logic [1:0] posRefSel;
   logic negRefSel;
   logic tempSensorPower;
   logic tempSensorRange;
   logic convIrq;
   logic sleepIn = 1'b0;
   logic wakeReq;
   logic [4:0] channelSelect;
   logic sampleHold;
   logic fixedRefEnable;
   logic [1:0] converterRefGain;
   logic [1:0] peripheralRefGain;
   logic [9:0] level = 10'h02A5;
   logic [7:0] rd;
   logic [15:0] res;
   int miscompares = 0;
   int n_checks = 0;
   int i;

   // ----------------------------------------
   // Clock, design and far side
   // ----------------------------------------
   always #4 clock = ~clock;

   sac_adc_ctrl #(.RES_W(10)) i_sac_adc_ctrl (.clock(clock), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .compIn(compIn), .rcOscIn(rcOscIn),
      .fvrReadyIn(1'b0), .sleepIn(sleepIn), .channelSelect(channelSelect), .muxConnect(muxConnect),
      .sampleHold(sampleHold), .dacCode(dacCode), .posRefSel(posRefSel), .negRefSel(negRefSel),
      .tempSensorPower(tempSensorPower), .tempSensorRange(tempSensorRange), .fixedRefEnable(fixedRefEnable),
      .converterRefGain(converterRefGain), .peripheralRefGain(peripheralRefGain), .convIrq(convIrq),
      .wakeReq(wakeReq));

   sac_analog_model #(.RES_W(10)) i_sac_analog_model (.dacCode(dacCode), .level(level), .compIn(compIn),
      .rcOscIn(rcOscIn));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Single verdict point for both the main sequence and the watchdog
   task automatic give_verdict;
      if (miscompares == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Holds the request until waitrequest is seen low at an edge, then releases; only the watchdog ends a hang
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h00_0000, d};
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      // Every index, unmapped ones too, reads zero after reset
      for (int k = 0; k < 8; k++) begin
         acc(1'b0, 3'(k), 8'h00);
         chk(rd, 16'h0000);
      end
      acc(1'b1, 3'h4, 8'hBF);
      chk({tempSensorPower, tempSensorRange}, 16'h0003);
      chk({fixedRefEnable, peripheralRefGain, converterRefGain}, 16'h001F);
      // Ready bit is read-only and its input is low
      acc(1'b0, 3'h4, 8'h00);
      chk(rd, 16'h00BF);
      acc(1'b1, 3'h4, 8'h00);
      chk({tempSensorPower, tempSensorRange}, 16'h0000);
      chk({fixedRefEnable, peripheralRefGain, converterRefGain}, 16'h0000);
      acc(1'b1, 3'h0, 8'h45);
      chk(muxConnect, 16'h0000);
      acc(1'b1, 3'h0, 8'h75);
      chk(muxConnect, 16'h0001);
      chk(channelSelect, 16'h001D);
      acc(1'b1, 3'h0, 8'h74);
      chk(muxConnect, 16'h0000);
      // Go in the same write as turn-on must not start; the sensor channel is never converted
      acc(1'b1, 3'h0, 8'h03);
      acc(1'b0, 3'h0, 8'h00);
      chk(rd, 16'h0001);
      acc(1'b1, 3'h1, 8'h07);
      chk({posRefSel, negRefSel}, 16'h0007);
      // Acquisition time after the last channel change
      repeat (8) @(posedge clock);
      // Divided clock right-justified awake, then RC clock left-justified asleep
      for (int k = 0; k < 2; k++) begin
         acc(1'b1, 3'h1, (k == 0) ? 8'hA0 : 8'h30);
         sleepIn <= (k == 1);
         acc(1'b1, 3'h0, 8'h03);
         i = 0;
         do begin
            acc(1'b0, 3'h0, 8'h00);
            i++;
         end while (rd[1] && i < 400);
         chk(rd, 16'h0001);
         chk(convIrq, 16'h0001);
         chk(wakeReq, 16'(k));
         acc(1'b0, 3'h2, 8'h00);
         res[15:8] = rd;
         acc(1'b0, 3'h3, 8'h00);
         res[7:0] = rd;
         chk(res, (k == 0) ? {6'h00, level} : {level, 6'h00});
         acc(1'b0, 3'h5, 8'h00);
         chk(rd, 16'h0001);
         acc(1'b1, 3'h5, 8'h01);
         chk(convIrq, 16'h0000);
      end
      sleepIn <= 1'b0;
      // Abort before any decision at the slowest division leaves a zero result
      acc(1'b1, 3'h1, 8'hE0);
      acc(1'b1, 3'h0, 8'h03);
      acc(1'b1, 3'h0, 8'h01);
      acc(1'b0, 3'h3, 8'h00);
      res[7:0] = rd;
      acc(1'b0, 3'h2, 8'h00);
      chk({rd, res[7:0]}, 16'h0000);
      // Abort at divide by four after three decisions: the rest copy the last decided bit
      acc(1'b1, 3'h1, 8'hC0);
      acc(1'b1, 3'h0, 8'h03);
      repeat (16) @(posedge clock);
      chk(sampleHold, 16'h0001);
      acc(1'b1, 3'h0, 8'h01);
      chk(sampleHold, 16'h0000);
      acc(1'b0, 3'h2, 8'h00);
      res[15:8] = rd;
      acc(1'b0, 3'h3, 8'h00);
      res[7:0] = rd;
      chk(res, {6'h00, level[9:7], {7{level[7]}}});
      // Sleep with a divided clock stops the conversion and keeps the old result
      sleepIn <= 1'b1;
      acc(1'b1, 3'h0, 8'h03);
      @(posedge clock);
      acc(1'b0, 3'h0, 8'h00);
      chk(rd, 16'h0001);
      chk(wakeReq, 16'h0000);
      acc(1'b0, 3'h3, 8'h00);
      chk(rd, 16'h00FF);
      sleepIn <= 1'b0;
      give_verdict();
   end

   // Watchdog well beyond the roughly eight hundred cycles the tests need
   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end
endmodule // tb_top
